// ---- rss_pkg.sv ----
// constants and carrier types for the reset source sequencer
// assumes a 100 MHz core clock and analog comparators outside the block
package rss_pkg;

	localparam int CLK_MHZ = 100;

	// ***************************************************
	// timing
	// ***************************************************
	localparam int BANDGAP_START_US = 70;
	localparam int BANDGAP_START_CYCLES_DEF = BANDGAP_START_US * CLK_MHZ;
	localparam int PIN_MIN_PULSE_NS = 2500;
	localparam int PIN_MIN_CYCLES = (PIN_MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int BRN_MIN_PULSE_NS = 2000;
	localparam int BRN_MIN_CYCLES = (BRN_MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int SMON_MIN_PULSE_NS = 2000;
	localparam int SMON_MIN_CYCLES = (SMON_MIN_PULSE_NS * CLK_MHZ + 999) / 1000;

	localparam int CNT_W = 16;
	localparam int FUSE_W = 2;

	// start-up delay in core cycles per fuse code
	localparam logic [CNT_W-1:0] STARTUP_CNT_0 = 16'h0010;
	localparam logic [CNT_W-1:0] STARTUP_CNT_1 = 16'h0100;
	localparam logic [CNT_W-1:0] STARTUP_CNT_2 = 16'h0400;
	localparam logic [CNT_W-1:0] STARTUP_CNT_3 = 16'h1000;

	// ***************************************************
	// synchroniser lane layout and idle levels
	// ***************************************************
	localparam int SYNC_W = 6;
	localparam int LANE_POR = 0;
	localparam int LANE_PIN_N = 1;
	localparam int LANE_BRN = 2;
	localparam int LANE_SMON = 3;
	localparam int LANE_WDOG = 4;
	localparam int LANE_TEST = 5;
	// powerup lane idles active, pin lane idles high
	localparam logic [SYNC_W-1:0] SYNC_INIT = 6'h03;

	typedef struct packed {
		logic testport;
		logic watchdog;
		logic brownout;
		logic pin;
		logic powerup;
	} rss_cause_type;

	localparam rss_cause_type CAUSE_RESET = 5'h01;

	typedef enum logic [1:0] {
		RSS_HOLD = 2'b00,
		RSS_STRETCH = 2'b01,
		RSS_RUN = 2'b10
	} rss_state_type;

endpackage : rss_pkg

// ---- rss_reset_sequencer.sv ----
// reset source merge, filtering, start-up stretch and supply monitor
// assumes comparator, pin, watchdog and test-port inputs are asynchronous
`timescale 1ns/100ps
module rss_reset_sequencer
	import rss_pkg::*;
#(
	parameter int BANDGAP_START_CYCLES = BANDGAP_START_CYCLES_DEF
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic powerup_low,
	input wire logic reset_pin_n,
	input wire logic brownout_low,
	input wire logic supply_low,
	input wire logic watchdog_expire,
	input wire logic watchdog_reset_enable,
	input wire logic testport_reset_bit,
	input wire logic brownout_enable_fuse,
	input wire logic [FUSE_W-1:0] startup_delay_fuse,
	input wire logic supply_monitor_on,
	input wire logic supply_low_irq_enable,
	input wire logic global_irq_enable,
	input wire logic supply_flag_clear,
	input wire logic cause_write,
	input wire rss_cause_type cause_write_data,
	output logic port_reset,
	output logic core_reset,
	output logic vector_fetch,
	output logic bandgap_enable,
	output logic bandgap_ready,
	output logic supply_low_flag,
	output logic supply_irq,
	output rss_cause_type reset_cause_register
);

	// ***************************************************
	// helpers
	// ***************************************************
	// saturating low-time counter: clears when condition drops
	function automatic logic [CNT_W-1:0] filt_next(
		input logic [CNT_W-1:0] cnt,
		input logic cond,
		input logic [CNT_W-1:0] lim
	);
		logic [CNT_W-1:0] res;
		res = '0;
		if (cond) begin
			if (cnt >= lim) begin
				res = lim;
			end else begin
				res = cnt + 16'h0001;
			end
		end
		return res;
	endfunction : filt_next

	function automatic logic [CNT_W-1:0] startup_term(input logic [FUSE_W-1:0] fuse);
		logic [CNT_W-1:0] res;
		res = STARTUP_CNT_0;
		case (fuse)
			2'h0: res = STARTUP_CNT_0;
			2'h1: res = STARTUP_CNT_1;
			2'h2: res = STARTUP_CNT_2;
			2'h3: res = STARTUP_CNT_3;
			default: res = STARTUP_CNT_0;
		endcase
		return res;
	endfunction : startup_term

	localparam logic [CNT_W-1:0] PIN_LIM = CNT_W'(PIN_MIN_CYCLES);
	localparam logic [CNT_W-1:0] BRN_LIM = CNT_W'(BRN_MIN_CYCLES);
	localparam logic [CNT_W-1:0] SMON_LIM = CNT_W'(SMON_MIN_CYCLES);
	localparam logic [CNT_W-1:0] BG_LIM = CNT_W'(BANDGAP_START_CYCLES);

	// ***************************************************
	// declarations
	// ***************************************************
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic [CNT_W-1:0] pin_cnt_reg;
	logic [CNT_W-1:0] brn_cnt_reg;
	logic [CNT_W-1:0] smon_cnt_reg;
	logic [CNT_W-1:0] bg_cnt_reg;
	logic [CNT_W-1:0] dly_cnt_reg;
	logic [CNT_W-1:0] dly_cnt_next;
	logic [CNT_W-1:0] dly_term;
	logic wd_prev_reg;
	logic wd_pulse_reg;
	logic smon_evt_reg;
	logic core_reset_reg;
	logic vector_fetch_reg;
	logic flag_reg;
	rss_cause_type cause_reg;
	rss_cause_type cause_next;
	rss_state_type state_reg;
	rss_state_type state_next;
	logic por_src;
	logic pin_src;
	logic brn_src;
	logic smon_low;
	logic any_src;
	logic smon_hit;

	// ***************************************************
	// asynchronous port reset
	// ***************************************************
	// raw pin, comparator and test-port levels with no clock in their path, plus the registered core_reset_reg term
	// limitation: brownout dips too short to reset the core still pulse the port pins
	assign port_reset = powerup_low | ~reset_pin_n | (brownout_low & brownout_enable_fuse)
		| testport_reset_bit | core_reset_reg;

	// ***************************************************
	// input synchronisers
	// ***************************************************
	always_ff @(posedge core_clk) begin
		if (reset) begin
			sync1_reg <= SYNC_INIT;
			sync2_reg <= SYNC_INIT;
		end else if (clk_en) begin
			sync1_reg <= {testport_reset_bit, watchdog_expire, supply_low, brownout_low,
				reset_pin_n, powerup_low};
			sync2_reg <= sync1_reg;
		end
	end

	// ***************************************************
	// bandgap reference
	// ***************************************************
	assign bandgap_enable = brownout_enable_fuse | supply_monitor_on;

	// detectors that lean on the reference read as quiet until it settles, except the raw brownout term in port_reset
	always_ff @(posedge core_clk) begin
		if (reset) begin
			bg_cnt_reg <= '0;
		end else if (clk_en) begin
			bg_cnt_reg <= filt_next(bg_cnt_reg, bandgap_enable, BG_LIM);
		end
	end

	assign bandgap_ready = bandgap_enable && (bg_cnt_reg >= BG_LIM);

	// ***************************************************
	// source qualification
	// ***************************************************
	// filters delay the core reset by their length; port pins react at once
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pin_cnt_reg <= '0;
		end else if (clk_en) begin
			pin_cnt_reg <= filt_next(pin_cnt_reg, ~sync2_reg[LANE_PIN_N], PIN_LIM);
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			brn_cnt_reg <= '0;
		end else if (clk_en) begin
			brn_cnt_reg <= filt_next(brn_cnt_reg,
				brownout_enable_fuse & bandgap_ready & sync2_reg[LANE_BRN],
				BRN_LIM);
		end
	end

	assign por_src = sync2_reg[LANE_POR];
	assign pin_src = ~sync2_reg[LANE_PIN_N] && (pin_cnt_reg >= PIN_LIM);
	assign brn_src = brownout_enable_fuse && (brn_cnt_reg >= BRN_LIM);

	// ***************************************************
	// watchdog pulse
	// ***************************************************
	// one cycle per expiry edge, so a stuck expiry line cannot hold reset
	always_ff @(posedge core_clk) begin
		if (reset) begin
			wd_prev_reg <= 1'b0;
		end else if (clk_en) begin
			wd_prev_reg <= sync2_reg[LANE_WDOG];
		end
	end

	// the falling edge of this pulse is what lets the stretch begin
	always_ff @(posedge core_clk) begin
		if (reset) begin
			wd_pulse_reg <= 1'b0;
		end else if (clk_en) begin
			wd_pulse_reg <= sync2_reg[LANE_WDOG] & ~wd_prev_reg
				& watchdog_reset_enable;
		end
	end

	// five causes only; supply monitor deliberately absent
	assign any_src = por_src | pin_src | wd_pulse_reg | brn_src
		| sync2_reg[LANE_TEST];

	// ***************************************************
	// start-up delay counter
	// ***************************************************
	// a bouncing source restarts the count, so it can only lengthen reset
	assign dly_term = startup_term(startup_delay_fuse);

	always_comb begin
		state_next = state_reg;
		dly_cnt_next = dly_cnt_reg;
		case (state_reg)
			RSS_HOLD: begin
				dly_cnt_next = '0;
				if (!any_src) begin
					state_next = RSS_STRETCH;
				end
			end
			RSS_STRETCH: begin
				if (any_src) begin
					state_next = RSS_HOLD;
					dly_cnt_next = '0;
				end else if (dly_cnt_reg >= dly_term - 16'h0001) begin
					state_next = RSS_RUN;
				end else begin
					dly_cnt_next = dly_cnt_reg + 16'h0001;
				end
			end
			RSS_RUN: begin
				dly_cnt_next = '0;
				if (any_src) begin
					state_next = RSS_HOLD;
				end
			end
			default: begin
				state_next = RSS_HOLD;
				dly_cnt_next = '0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg <= RSS_HOLD;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			dly_cnt_reg <= '0;
		end else if (clk_en) begin
			dly_cnt_reg <= dly_cnt_next;
		end
	end

	// ***************************************************
	// core reset and vector fetch
	// ***************************************************
	// core_reset doubles as the io register initialise level
	always_ff @(posedge core_clk) begin
		if (reset) begin
			core_reset_reg <= 1'b1;
		end else if (clk_en) begin
			core_reset_reg <= (state_next != RSS_RUN);
		end
	end

	// one pulse in the first running cycle, where fetch starts at the vector
	always_ff @(posedge core_clk) begin
		if (reset) begin
			vector_fetch_reg <= 1'b0;
		end else if (clk_en) begin
			vector_fetch_reg <= core_reset_reg & (state_next == RSS_RUN);
		end
	end

	assign core_reset = core_reset_reg;
	assign vector_fetch = vector_fetch_reg;

	// ***************************************************
	// supply monitor
	// ***************************************************
	assign smon_low = supply_monitor_on & bandgap_ready & sync2_reg[LANE_SMON];
	assign smon_hit = smon_low && (smon_cnt_reg >= SMON_LIM);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			smon_cnt_reg <= '0;
		end else if (clk_en) begin
			smon_cnt_reg <= filt_next(smon_cnt_reg, smon_low, SMON_LIM);
		end
	end

	// remembers the episode so that one long dip sets the flag only once
	always_ff @(posedge core_clk) begin
		if (reset) begin
			smon_evt_reg <= 1'b0;
		end else if (clk_en) begin
			smon_evt_reg <= smon_hit;
		end
	end

	// hardware set wins over a same-cycle software clear
	always_ff @(posedge core_clk) begin
		if (reset) begin
			flag_reg <= 1'b0;
		end else if (clk_en) begin
			if (smon_hit && !smon_evt_reg) begin
				flag_reg <= 1'b1;
			end else if (supply_flag_clear) begin
				flag_reg <= 1'b0;
			end
		end
	end

	assign supply_low_flag = flag_reg;
	assign supply_irq = flag_reg & supply_low_irq_enable & global_irq_enable;

	// ***************************************************
	// reset cause flags
	// ***************************************************
	// sets from live sources win over a same-cycle zero write
	always_comb begin
		cause_next = cause_reg;
		if (cause_write) begin
			cause_next = cause_reg & cause_write_data;
		end
		if (por_src) begin
			cause_next = CAUSE_RESET;
		end else begin
			cause_next.pin = cause_next.pin | pin_src;
			cause_next.watchdog = cause_next.watchdog | wd_pulse_reg;
			cause_next.brownout = cause_next.brownout | brn_src;
			cause_next.testport = cause_next.testport | sync2_reg[LANE_TEST];
		end
	end

	// block reset stands for first power-up, hence powerup flag set
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cause_reg <= CAUSE_RESET;
		end else if (clk_en) begin
			cause_reg <= cause_next;
		end
	end

	assign reset_cause_register = cause_reg;

endmodule : rss_reset_sequencer

// ---- rss_source_model.sv ----
// far-side model: supply comparators, reset pin, watchdog and test-port bit
// assumes callers enter its tasks just after a rising edge of core_clk
`timescale 1ns/100ps
module rss_source_model
	import rss_pkg::*;
(
	input wire logic core_clk,
	output logic powerup_low,
	output logic reset_pin_n,
	output logic brownout_low,
	output logic supply_low,
	output logic watchdog_expire,
	output logic testport_reset_bit
);
	// one active flag per lane; the pin lane is inverted at the wire
	logic [SYNC_W-1:0] act_reg = 6'h00;
	assign powerup_low = act_reg[LANE_POR];
	assign reset_pin_n = ~act_reg[LANE_PIN_N];
	assign brownout_low = act_reg[LANE_BRN];
	assign supply_low = act_reg[LANE_SMON];
	assign watchdog_expire = act_reg[LANE_WDOG];
	assign testport_reset_bit = act_reg[LANE_TEST];

	task automatic hold(input int lane, input logic v);
		act_reg[lane] = v;
	endtask : hold

	// short pulses test the filters, long ones a real event
	task automatic pulse(input int lane, input int n);
		act_reg[lane] = 1'h1;
		repeat (n) @(posedge core_clk);
		#1;
		act_reg[lane] = 1'h0;
	endtask : pulse
endmodule : rss_source_model

// ---- rss_reset_chk.sv ----
// port checker for the reset source sequencer
// assumes a bind into rss_reset_sequencer, one clock domain
`timescale 1ns/100ps
module rss_reset_chk
	import rss_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic powerup_low,
	input wire logic reset_pin_n,
	input wire logic brownout_low,
	input wire logic testport_reset_bit,
	input wire logic brownout_enable_fuse,
	input wire logic supply_monitor_on,
	input wire logic supply_low_irq_enable,
	input wire logic global_irq_enable,
	input wire logic supply_flag_clear,
	input wire logic port_reset,
	input wire logic core_reset,
	input wire logic vector_fetch,
	input wire logic bandgap_enable,
	input wire logic bandgap_ready,
	input wire logic supply_low_flag,
	input wire logic supply_irq,
	input wire rss_cause_type reset_cause_register
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	AST_PORT_ASYNC: assert property (port_reset == (powerup_low | ~reset_pin_n | core_reset
		| testport_reset_bit | (brownout_low & brownout_enable_fuse))) else $error("port reset");
	AST_BANDGAP: assert property (bandgap_enable == (brownout_enable_fuse | supply_monitor_on))
		else $error("bandgap enable");
	AST_IRQ_GATE: assert property (
		supply_irq == (supply_low_flag & supply_low_irq_enable & global_irq_enable)) else $error("irq");
	AST_POR_HOLD: assert property ((powerup_low && clk_en) [*6] |-> core_reset)
		else $error("powerup hold");
	AST_TEST_HOLD: assert property ((testport_reset_bit && clk_en) [*6] |-> core_reset)
		else $error("test hold");
	AST_VECTOR: assert property (vector_fetch |-> !core_reset && $past(core_reset))
		else $error("vector fetch");
	AST_STRETCH: assert property ($fell(core_reset) |-> $past(core_reset, 8))
		else $error("stretch short");
	AST_FLAG_KEEP: assert property (
		supply_low_flag && !supply_flag_clear && clk_en |=> supply_low_flag) else $error("flag lost");
	AST_POR_FLAG: assert property ($fell(reset) |-> reset_cause_register.powerup)
		else $error("powerup flag");
	AST_BG_START: assert property ($rose(bandgap_enable) |-> !bandgap_ready [*8])
		else $error("bandgap early");
endmodule : rss_reset_chk

// ---- tb.sv ----
// self-checking bench for the reset source sequencer
// assumes rss_source_model drives the six asynchronous sources
`timescale 1ns/100ps
module tb;
	import rss_pkg::*;
	logic core_clk = 1'h0;
	logic reset = 1'h1;
	logic clk_en = 1'h1;
	logic wden = 1'h0, bfuse = 1'h0, mon = 1'h0, ie = 1'h0, gie = 1'h0, fclr = 1'h0, cw = 1'h0;
	logic [FUSE_W-1:0] sfuse = 2'h0;
	rss_cause_type cwd = 5'h00;
	logic por, pin_n, brn, slow, wdx, tst, prst, crst, vf, bge, bgr, flag, irq;
	rss_cause_type cause;
	logic [CNT_W-1:0] terms [4] = '{STARTUP_CNT_0, STARTUP_CNT_1, STARTUP_CNT_2, STARTUP_CNT_3};
	int mismatches = 0;
	int check_count = 0;
	int n;
	always #5 core_clk = ~core_clk;
	rss_source_model u_rss_source_model (.core_clk(core_clk), .powerup_low(por),
		.reset_pin_n(pin_n), .brownout_low(brn), .supply_low(slow), .watchdog_expire(wdx),
		.testport_reset_bit(tst));
	rss_reset_sequencer #(.BANDGAP_START_CYCLES(20)) u_rss_reset_sequencer (.core_clk(core_clk),
		.reset(reset), .clk_en(clk_en), .powerup_low(por), .reset_pin_n(pin_n), .brownout_low(brn),
		.supply_low(slow), .watchdog_expire(wdx), .watchdog_reset_enable(wden),
		.testport_reset_bit(tst), .brownout_enable_fuse(bfuse), .startup_delay_fuse(sfuse),
		.supply_monitor_on(mon), .supply_low_irq_enable(ie), .global_irq_enable(gie),
		.supply_flag_clear(fclr), .cause_write(cw), .cause_write_data(cwd), .port_reset(prst),
		.core_reset(crst), .vector_fetch(vf), .bandgap_enable(bge), .bandgap_ready(bgr),
		.supply_low_flag(flag), .supply_irq(irq), .reset_cause_register(cause));
	// ****************
	// tasks
	// ****************
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : cyc
	task automatic chk(input string nm, input logic ex, input logic got);
		check_count++;
		if (got !== ex) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task automatic chk_cause(input rss_cause_type ex);
		check_count++;
		if (cause !== ex) begin
			mismatches++;
			$display("mismatch cause expected %h seen %h", ex, cause);
		end
	endtask : chk_cause
	// bounded wait for the core to leave reset
	task automatic release_len(output int k);
		k = 0;
		while (crst !== 1'h0 && k < 6000) begin
			cyc(1);
			k++;
		end
		if (crst !== 1'h0) begin
			mismatches++;
			$display("mismatch release expected 0 seen %h", crst);
		end
	endtask : release_len
	// a write keeps flags written one and clears flags written zero
	task automatic wr_cause(input rss_cause_type d, input rss_cause_type ex);
		cw = 1'h1;
		cwd = d;
		cyc(1);
		cw = 1'h0;
		chk_cause(ex);
		cyc(1);
	endtask : wr_cause
	task automatic results;
		if (mismatches == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results
	// ****************
	// tests
	// ****************
	initial begin
		#200000;
		mismatches++;
		results();
	end
	initial begin
		cyc(2);
		reset = 1'h0;
		chk_cause(CAUSE_RESET);
		chk("core_reset", 1'h1, crst);
		for (int f = 0; f < 4; f++) begin
			sfuse = f[1:0];
			u_rss_source_model.hold(LANE_POR, 1'h1);
			cyc(10);
			u_rss_source_model.hold(LANE_POR, 1'h0);
			release_len(n);
			chk("stretch", 1'h1, n >= terms[f] && n <= terms[f] + 5);
			chk("vector", 1'h1, vf);
			cyc(1);
			chk("vector_end", 1'h0, vf);
		end
		sfuse = 2'h1;
		u_rss_source_model.pulse(LANE_POR, 10);
		cyc(100);
		u_rss_source_model.pulse(LANE_POR, 10);
		release_len(n);
		chk("restart", 1'h1, n >= terms[1]);
		sfuse = 2'h0;
		wr_cause(5'h1F, 5'h01);
		wr_cause(5'h1E, 5'h00);
		wr_cause(5'h00, 5'h00);
		u_rss_source_model.hold(LANE_PIN_N, 1'h1);
		#2;
		chk("port_pin", 1'h1, prst);
		cyc(99);
		u_rss_source_model.hold(LANE_PIN_N, 1'h0);
		cyc(10);
		chk("pin_short", 1'h0, crst);
		u_rss_source_model.pulse(LANE_PIN_N, 300);
		chk("pin_long", 1'h1, crst);
		release_len(n);
		chk_cause(5'h02);
		wr_cause(5'h00, 5'h00);
		u_rss_source_model.pulse(LANE_WDOG, 1);
		cyc(10);
		chk("wdog_off", 1'h0, crst);
		wden = 1'h1;
		u_rss_source_model.pulse(LANE_WDOG, 1);
		cyc(6);
		chk("wdog_on", 1'h1, crst);
		release_len(n);
		chk("wdog_len", 1'h1, n <= terms[0] + 5);
		chk_cause(5'h08);
		wr_cause(5'h00, 5'h00);
		u_rss_source_model.pulse(LANE_TEST, 500);
		chk("test_hold", 1'h1, crst);
		release_len(n);
		chk_cause(5'h10);
		wr_cause(5'h00, 5'h00);
		u_rss_source_model.pulse(LANE_BRN, 300);
		chk("brn_off", 1'h0, crst);
		bfuse = 1'h1;
		cyc(30);
		chk("bg_on", 1'h1, bge & bgr);
		u_rss_source_model.pulse(LANE_BRN, 100);
		cyc(5);
		chk("brn_short", 1'h0, crst);
		u_rss_source_model.pulse(LANE_BRN, 300);
		chk("brn_long", 1'h1, crst);
		release_len(n);
		chk_cause(5'h04);
		bfuse = 1'h0;
		cyc(1);
		chk("bg_off", 1'h0, bge);
		clk_en = 1'h0;
		u_rss_source_model.pulse(LANE_TEST, 20);
		chk("freeze", 1'h0, crst);
		clk_en = 1'h1;
		cyc(5);
		chk("freeze_end", 1'h0, crst);
		mon = 1'h1;
		ie = 1'h1;
		gie = 1'h1;
		cyc(2);
		chk("bg_wait", 1'h0, bgr);
		cyc(25);
		u_rss_source_model.hold(LANE_SMON, 1'h1);
		cyc(100);
		chk("flag_early", 1'h0, flag);
		cyc(150);
		chk("irq", 1'h1, flag & irq & ~crst);
		u_rss_source_model.hold(LANE_SMON, 1'h0);
		gie = 1'h0;
		cyc(1);
		chk("irq_mask", 1'h0, irq);
		fclr = 1'h1;
		cyc(1);
		fclr = 1'h0;
		cyc(1);
		chk("flag_clr", 1'h0, flag);
		mon = 1'h0;
		results();
	end
endmodule : tb
bind rss_reset_sequencer rss_reset_chk u_rss_reset_chk (.core_clk(core_clk), .reset(reset),
	.clk_en(clk_en), .powerup_low(powerup_low), .reset_pin_n(reset_pin_n),
	.brownout_low(brownout_low), .testport_reset_bit(testport_reset_bit),
	.brownout_enable_fuse(brownout_enable_fuse), .supply_monitor_on(supply_monitor_on),
	.supply_low_irq_enable(supply_low_irq_enable), .global_irq_enable(global_irq_enable),
	.supply_flag_clear(supply_flag_clear), .port_reset(port_reset), .core_reset(core_reset),
	.vector_fetch(vector_fetch), .bandgap_enable(bandgap_enable), .bandgap_ready(bandgap_ready),
	.supply_low_flag(supply_low_flag), .supply_irq(supply_irq),
	.reset_cause_register(reset_cause_register));
